// *** verilog/dpr_defs.vh ***
// Shared constants for the dual-port block RAM: register map, fields, geometry
`ifndef DPR_DEFS_VH
`define DPR_DEFS_VH

// Register byte offsets on the control bus
`define DPR_CTRL_OFF    4'h0
`define DPR_STAT_OFF    4'h4

// Control register fields and reset value
`define DPR_CTRL_EN_A   0
`define DPR_CTRL_EN_B   1
`define DPR_CTRL_RST    2'h3

// Status register fields (write one to clear)
`define DPR_STAT_COLL   0

// Storage geometry: 512 words of 32 data bits plus 4 parity bits
`define DPR_WORDS       512
`define DPR_WORD_AW     9
`define DPR_WORD_W      36
`define DPR_DATA_W      32
`define DPR_PAR_W       4
`define DPR_ADDR_W      14

// Layout of one synchronised port bundle
`define DPR_BUN_W       54
`define DPR_BUN_CLK     53
`define DPR_BUN_EN      52
`define DPR_BUN_WE      51
`define DPR_BUN_SSR     50
`define DPR_BUN_ADR_HI  49
`define DPR_BUN_ADR_LO  36

// Synchroniser stages to fill after reset before port edges count
`define DPR_SYNC_FILL   2'h3

`endif

// *** verilog/dpr_dual_port_ram.v ***
// Dual-port 18 Kb block RAM with configurable aspect ratio and a small Wishbone control slave
//
// Overview of operation
// - 18 Kb shared array, two independent ports
// - Both ports identical, reach any location
// - Per-port polarity of clock, enable, write, init
// - Port inputs: clock, enable, write, init, address
// - Separate write and read data with parity
// - Ports act only at active clock edge
// - Rising edge default, falling edge selectable
// - Read data updates on the sampling edge
// - Widths 9, 18, 36 reach full 18 Kb
// - Widths 1, 2, 4 reach 16 Kb only
// - Same ratios in single or dual use
// - One parity bit stored per data byte
`include "dpr_defs.vh"

module dpr_dual_port_ram #(
   parameter W_A       = 36,                                   // Port A width: 1,2,4,9,18,36
   parameter W_B       = 36,                                   // Port B width: 1,2,4,9,18,36
   parameter CLK_INV_A = 0,                                    // 1: port A samples on falling edge
   parameter EN_INV_A  = 0,                                    // 1: port A enable active low
   parameter WE_INV_A  = 0,                                    // 1: port A write enable active low
   parameter SSR_INV_A = 0,                                    // 1: port A output init active low
   parameter CLK_INV_B = 0,                                    // 1: port B samples on falling edge
   parameter EN_INV_B  = 0,                                    // 1: port B enable active low
   parameter WE_INV_B  = 0,                                    // 1: port B write enable active low
   parameter SSR_INV_B = 0,                                    // 1: port B output init active low
   parameter [35:0] SRVAL_A = 36'h000000000,                   // Port A init value {par,data}
   parameter [35:0] SRVAL_B = 36'h000000000,                   // Port B init value {par,data}
   parameter AW_A = (W_A == 1) ? 14 : (W_A == 2) ? 13 : (W_A == 4) ? 12 :
                    (W_A == 9) ? 11 : (W_A == 18) ? 10 : 9,    // Port A address width
   parameter AW_B = (W_B == 1) ? 14 : (W_B == 2) ? 13 : (W_B == 4) ? 12 :
                    (W_B == 9) ? 11 : (W_B == 18) ? 10 : 9,    // Port B address width
   parameter DW_A = (W_A < 9) ? W_A : (W_A / 9) * 8,           // Port A data width
   parameter DW_B = (W_B < 9) ? W_B : (W_B / 9) * 8,           // Port B data width
   parameter PW_A = (W_A < 9) ? 1 : W_A / 9,                   // Port A parity width
   parameter PW_B = (W_B < 9) ? 1 : W_B / 9                    // Port B parity width
) (
   input  wire            clk_i,                 // System clock, 50 MHz
   input  wire            reset_n_i,             // Asynchronous reset, active low
   input  wire            wb_cyc_i,              // Wishbone cycle
   input  wire            wb_stb_i,              // Wishbone strobe
   input  wire            wb_we_i,               // Wishbone write
   input  wire [3:0]      wb_adr_i,              // Wishbone byte address
   input  wire [3:0]      wb_sel_i,              // Wishbone byte selects
   input  wire [31:0]     wb_dat_i,              // Wishbone write data
   output wire [31:0]     wb_dat_o,              // Wishbone read data
   output wire            wb_ack_o,              // Wishbone acknowledge
   input  wire            a_clk_i,               // Port A clock pin
   input  wire            a_en_i,                // Port A enable
   input  wire            a_we_i,                // Port A write enable
   input  wire            a_sync_output_init_i,  // Port A synchronous output init
   input  wire [AW_A-1:0] a_addr_i,              // Port A address
   input  wire [DW_A-1:0] a_wdata_i,             // Port A write data
   input  wire [PW_A-1:0] a_wpar_i,              // Port A write parity
   output wire [DW_A-1:0] a_rdata_o,             // Port A read data
   output wire [PW_A-1:0] a_rpar_o,              // Port A read parity
   input  wire            b_clk_i,               // Port B clock pin
   input  wire            b_en_i,                // Port B enable
   input  wire            b_we_i,                // Port B write enable
   input  wire            b_sync_output_init_i,  // Port B synchronous output init
   input  wire [AW_B-1:0] b_addr_i,              // Port B address
   input  wire [DW_B-1:0] b_wdata_i,             // Port B write data
   input  wire [PW_B-1:0] b_wpar_i,              // Port B write parity
   output wire [DW_B-1:0] b_rdata_o,             // Port B read data
   output wire [PW_B-1:0] b_rpar_o               // Port B read parity
);

   // Low address bits that pick a lane inside a 36-bit word
   function integer f_lb;
      input integer w;
      begin
         f_lb = (w == 1) ? 5 : (w == 2) ? 4 : (w == 4) ? 3 : (w == 9) ? 2 : (w == 18) ? 1 : 0;
      end
   endfunction

   // Bytes per access for parity widths, zero for narrow widths
   function integer f_nb;
      input integer w;
      begin
         f_nb = (w >= 9) ? w / 9 : 0;
      end
   endfunction

   // Whether word bit i belongs to the lane; parity bits only in wide modes
   function integer f_in;
      input integer w;
      input integer lane;
      input integer i;
      integer nb;
      begin
         nb = f_nb(w);
         if (i < 32)
            f_in = (nb == 0) ? ((i / w) == lane) : (((i / 8) / nb) == lane);
         else
            f_in = (nb == 0) ? 0 : (((i - 32) / nb) == lane);
      end
   endfunction

   // Position in the low-aligned {par,data} image that word bit i maps to
   function integer f_src;
      input integer w;
      input integer lane;
      input integer i;
      integer nb;
      begin
         nb = f_nb(w);
         if (i < 32)
            f_src = (nb == 0) ? (i - lane * w) : (i - lane * nb * 8);
         else
            f_src = i - lane * nb;
      end
   endfunction

   // Lane number from the low address bits
   function integer f_lane;
      input integer w;
      input [13:0] a;
      begin
         f_lane = a & ((1 << f_lb(w)) - 1);
      end
   endfunction

   // Word index: the address bits above the lane
   function [8:0] f_word;
      input integer w;
      input [13:0] a;
      reg [13:0] t;
      begin
         t = a >> f_lb(w);
         f_word = t[8:0];
      end
   endfunction

   // Bits of the word touched by one access
   function [35:0] f_mask;
      input integer w;
      input [13:0] a;
      integer i;
      integer lane;
      begin
         f_mask = 36'h000000000;
         lane = f_lane(w, a);
         for (i = 0; i < 36; i = i + 1)
            f_mask[i] = (f_in(w, lane, i) != 0);
      end
   endfunction

   // Place low-aligned write image into its lane
   function [35:0] f_spread;
      input integer w;
      input [13:0] a;
      input [35:0] img;
      integer i;
      integer lane;
      begin
         f_spread = 36'h000000000;
         lane = f_lane(w, a);
         for (i = 0; i < 36; i = i + 1)
            if (f_in(w, lane, i) != 0)
               f_spread[i] = img[f_src(w, lane, i)];
      end
   endfunction

   // Pull the lane out of a word into low-aligned {par,data}
   function [35:0] f_gather;
      input integer w;
      input [13:0] a;
      input [35:0] word;
      integer i;
      integer lane;
      begin
         f_gather = 36'h000000000;
         lane = f_lane(w, a);
         for (i = 0; i < 36; i = i + 1)
            if (f_in(w, lane, i) != 0)
               f_gather[f_src(w, lane, i)] = word[i];
      end
   endfunction

   // Shared storage: 16 Kb data plus 2 Kb parity
   reg  [`DPR_WORD_W-1:0] mem [0:`DPR_WORDS-1];

   // Zero-extended pin bundles, one per port
   wire [13+AW_A:0] a_addr_x = {14'h0, a_addr_i};
   wire [13+AW_B:0] b_addr_x = {14'h0, b_addr_i};
   wire [31+DW_A:0] a_data_x = {32'h00000000, a_wdata_i};
   wire [31+DW_B:0] b_data_x = {32'h00000000, b_wdata_i};
   wire [3+PW_A:0]  a_par_x  = {4'h0, a_wpar_i};
   wire [3+PW_B:0]  b_par_x  = {4'h0, b_wpar_i};
   wire [`DPR_BUN_W-1:0] bun_in [0:1];
   assign bun_in[0] = {a_clk_i, a_en_i, a_we_i, a_sync_output_init_i, a_addr_x[13:0], a_par_x[3:0], a_data_x[31:0]};
   assign bun_in[1] = {b_clk_i, b_en_i, b_we_i, b_sync_output_init_i, b_addr_x[13:0], b_par_x[3:0], b_data_x[31:0]};

   // Control and status registers
   reg  [1:0]  ctrl;
   reg         stat_coll;
   reg  [31:0] wb_dat;
   reg         wb_ack;

   // Per-port decoded access, shared by the array write process
   wire [1:0]  p_wr;
   wire [8:0]  p_word [0:1];
   wire [35:0] p_mask [0:1];
   wire [35:0] p_img  [0:1];
   wire [35:0] p_rd   [0:1];

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : port
         localparam integer WG   = (g == 0) ? W_A : W_B;
         localparam         CINV = (g == 0) ? CLK_INV_A : CLK_INV_B;
         localparam         EINV = (g == 0) ? EN_INV_A : EN_INV_B;
         localparam         WINV = (g == 0) ? WE_INV_A : WE_INV_B;
         localparam         SINV = (g == 0) ? SSR_INV_A : SSR_INV_B;
         localparam [35:0]  SRV  = (g == 0) ? SRVAL_A : SRVAL_B;

         reg  [`DPR_BUN_W-1:0] s1;
         reg  [`DPR_BUN_W-1:0] s2;
         reg  [`DPR_BUN_W-1:0] s3;
         reg  [35:0]           rd_q;
         reg  [1:0]            fill;
         wire                  c_now;
         wire                  c_old;
         wire                  edge_hit;
         wire                  en_on;
         wire                  we_on;
         wire                  ssr_on;
         wire [13:0]           addr;

         // Pins cross in through two flops; third stage gives the edge and setup-time values
         always @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               s1 <= {`DPR_BUN_W{1'b0}};
               s2 <= {`DPR_BUN_W{1'b0}};
               s3 <= {`DPR_BUN_W{1'b0}};
               fill <= 2'h0;
            end else begin
               s1 <= bun_in[g];
               s2 <= s1;
               s3 <= s2;
               // Count the fill-up once, then stay
               if (fill != `DPR_SYNC_FILL)
                  fill <= fill + 2'h1;
            end
         end

         // Active edge after optional inversion; rising unless inverted
         assign c_now    = s2[`DPR_BUN_CLK] ^ (CINV != 0);
         assign c_old    = s3[`DPR_BUN_CLK] ^ (CINV != 0);
         // Edges count only once both compare stages hold real pin samples;
         // a pin resting at the active level through reset would fake one
         assign edge_hit = c_now & ~c_old & (fill == `DPR_SYNC_FILL);

         // Control polarities are fixed per instance
         assign en_on  = (s3[`DPR_BUN_EN]  ^ (EINV != 0)) & ctrl[g];
         assign we_on  = s3[`DPR_BUN_WE]  ^ (WINV != 0);
         assign ssr_on = s3[`DPR_BUN_SSR] ^ (SINV != 0);
         assign addr   = s3[`DPR_BUN_ADR_HI:`DPR_BUN_ADR_LO];

         // Write only on the sampling edge with enable; narrow widths never touch parity
         assign p_wr[g]   = edge_hit & en_on & we_on;
         assign p_word[g] = f_word(WG, addr);
         assign p_mask[g] = f_mask(WG, addr);
         assign p_img[g]  = f_spread(WG, addr, s3[35:0]);

         // Read-before-write output register; held when not enabled
         always @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               rd_q <= 36'h000000000;
            end else if (edge_hit && en_on) begin
               if (ssr_on)
                  rd_q <= SRV;
               else
                  rd_q <= f_gather(WG, addr, mem[p_word[g]]);
            end
         end
         assign p_rd[g] = rd_q;
      end
   endgenerate

   // Same aspect ratios whichever ports are used; unused port just stays idle

   // Port B sees port A's lanes when both hit one word, so A's bits outside B's lanes are kept
   wire        same_word = p_wr[0] & p_wr[1] & (p_word[0] == p_word[1]);
   wire [35:0] a_merged  = (mem[p_word[0]] & ~p_mask[0]) | (p_img[0] & p_mask[0]);
   wire [35:0] b_base    = same_word ? a_merged : mem[p_word[1]];
   wire        coll_hit  = same_word & ((p_mask[0] & p_mask[1]) != 36'h000000000);

   // Array writes; on overlapping bits port B wins
   always @(posedge clk_i) begin
      if (p_wr[0])
         mem[p_word[0]] <= a_merged;
      if (p_wr[1])
         mem[p_word[1]] <= (b_base & ~p_mask[1]) | (p_img[1] & p_mask[1]);
   end

   // Parity bits are stored as given; nothing here checks them

   // Bus slave: one-cycle registered ack, unmapped reads return zero
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack;
   // Writes commit on the edge where the master sees ack, never before
   wire wb_wr  = wb_cyc_i & wb_stb_i & wb_ack & wb_we_i & wb_sel_i[0];
   wire coll_clr = wb_wr && (wb_adr_i == `DPR_STAT_OFF) && wb_dat_i[`DPR_STAT_COLL];

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wb_ack    <= 1'b0;
         wb_dat    <= 32'h00000000;
         ctrl      <= `DPR_CTRL_RST;
         stat_coll <= 1'b0;
      end else begin
         wb_ack <= wb_req;
         if (wb_wr && wb_adr_i == `DPR_CTRL_OFF)
            ctrl <= wb_dat_i[1:0];
         // Set beats clear so a collision in the clearing cycle is kept
         stat_coll <= (stat_coll & ~coll_clr) | coll_hit;
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               `DPR_CTRL_OFF: wb_dat <= {30'h0, ctrl};
               `DPR_STAT_OFF: wb_dat <= {31'h0, stat_coll};
               default:       wb_dat <= 32'h00000000;
            endcase
         end
      end
   end

   // Outputs straight from flops
   assign wb_dat_o  = wb_dat;
   assign wb_ack_o  = wb_ack;
   assign a_rdata_o = p_rd[0][DW_A-1:0];
   assign a_rpar_o  = p_rd[0][32+PW_A-1:32];
   assign b_rdata_o = p_rd[1][DW_B-1:0];
   assign b_rpar_o  = p_rd[1][32+PW_B-1:32];

endmodule

// *** sim/dpr_ram_props.sv ***
// Timing checks on the bus and the RAM port outputs
module dpr_ram_props #(
   parameter W_A  = 36,
   parameter W_B  = 36,
   parameter DW_A = (W_A < 9) ? W_A : (W_A / 9) * 8,
   parameter DW_B = (W_B < 9) ? W_B : (W_B / 9) * 8
) (
   input wire            clk_i,     // Clock
   input wire            reset_n_i, // Reset
   input wire            wb_cyc_i,  // Cycle
   input wire            wb_stb_i,  // Strobe
   input wire            wb_we_i,   // Write
   input wire [3:0]      wb_adr_i,  // Address
   input wire [31:0]     wb_dat_o,  // Read data
   input wire            wb_ack_o,  // Ack
   input wire            a_clk_i,   // A clock pin
   input wire            a_en_i,    // A enable
   input wire [DW_A-1:0] a_rdata_o, // A read data
   input wire            b_clk_i,   // B clock pin
   input wire [DW_B-1:0] b_rdata_o  // B read data
);
   timeunit 1ns;
   timeprecision 1ps;
   wire req;
   // Bus request present
   assign req = wb_cyc_i & wb_stb_i;
   // One clock domain, quiet in reset
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);
   property p_ack_take; req && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_take: assert property (p_ack_take) else $error("ack late");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_no_ack; !req |=> !wb_ack_o; endproperty
   a_no_ack: assert property (p_no_ack) else $error("ack without request");
   property p_dat_hold; !(req && !wb_we_i) |=> $stable(wb_dat_o); endproperty
   a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
   property p_unmapped; req && !wb_we_i && !wb_ack_o && wb_adr_i != 4'h0 && wb_adr_i != 4'h4 |=> wb_dat_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   // Slow port clocks: the update lands well inside these windows
   property p_a_quiet; $stable(a_clk_i) [*6] |-> $stable(a_rdata_o); endproperty
   a_a_quiet: assert property (p_a_quiet) else $error("A output moved without edge");
   property p_b_quiet; $stable(b_clk_i) [*6] |-> $stable(b_rdata_o); endproperty
   a_b_quiet: assert property (p_b_quiet) else $error("B output moved without edge");
   property p_a_en_hold; !a_en_i [*8] |-> $stable(a_rdata_o); endproperty
   a_a_en_hold: assert property (p_a_en_hold) else $error("A output moved while disabled");
   property p_a_fall; a_clk_i [*5] ##1 !a_clk_i |-> $stable(a_rdata_o) [*5]; endproperty
   a_a_fall: assert property (p_a_fall) else $error("A output moved on falling edge");
endmodule

bind dpr_dual_port_ram dpr_ram_props #(.W_A(W_A), .W_B(W_B)) i_dpr_ram_props (.clk_i, .reset_n_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .a_clk_i, .a_en_i, .a_rdata_o, .b_clk_i, .b_rdata_o);

// *** sim/dpr_user_logic.sv ***
// User logic model on both RAM ports
module dpr_user_logic (
   input  logic        clk_i,     // Clock
   output logic        a_clk_o,   // A clock
   output logic        a_en_o,    // A enable
   output logic        a_we_o,    // A write
   output logic        a_init_o,  // A init
   output logic [8:0]  a_addr_o,  // A address
   output logic [31:0] a_wdata_o, // A data
   output logic [3:0]  a_wpar_o,  // A parity
   input  logic [31:0] a_rdata_i, // A read data
   input  logic [3:0]  a_rpar_i,  // A read parity
   output logic        b_clk_o,   // B clock
   output logic        b_en_o,    // B enable
   output logic        b_we_o,    // B write
   output logic        b_init_o,  // B init
   output logic [10:0] b_addr_o,  // B address
   output logic [7:0]  b_wdata_o, // B data
   output logic [0:0]  b_wpar_o,  // B parity
   input  logic [7:0]  b_rdata_i, // B read data
   input  logic [0:0]  b_rpar_i   // B read parity
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle pins, port clocks low
   initial begin
      {a_clk_o, a_en_o, a_we_o, a_init_o, a_addr_o, a_wdata_o, a_wpar_o} = '0;
      {b_clk_o, b_en_o, b_we_o, b_init_o, b_addr_o, b_wdata_o, b_wpar_o} = '0;
   end
   // Pins held 1 cycle before and 10 after the rise; parity made here since the RAM never does
   task automatic a_op(input logic en, we, ini, input logic [8:0] ad, input logic [31:0] d,
                       output logic [31:0] q, output logic [3:0] p);
      {a_en_o, a_we_o, a_init_o, a_addr_o, a_wdata_o} <= {en, we, ini, ad, d};
      a_wpar_o <= {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
      @(posedge clk_i);
      a_clk_o <= 1'b1;
      repeat (5) @(posedge clk_i);
      a_clk_o <= 1'b0;
      repeat (5) @(posedge clk_i);
      {q, p} = {a_rdata_i, a_rpar_i};
      {a_en_o, a_addr_o, a_wdata_o} <= {1'b0, ~ad, ~d}; // Released lines lose old value
      @(posedge clk_i);
   endtask
   // Same access on the byte-wide port
   task automatic b_op(input logic en, we, ini, input logic [10:0] ad, input logic [7:0] d,
                       output logic [7:0] q, output logic [0:0] p);
      {b_en_o, b_we_o, b_init_o, b_addr_o, b_wdata_o} <= {en, we, ini, ad, d};
      b_wpar_o <= ^d;
      @(posedge clk_i);
      b_clk_o <= 1'b1;
      repeat (5) @(posedge clk_i);
      b_clk_o <= 1'b0;
      repeat (5) @(posedge clk_i);
      {q, p} = {b_rdata_i, b_rpar_i};
      {b_en_o, b_addr_o, b_wdata_o} <= {1'b0, ~ad, ~d};
      @(posedge clk_i);
   endtask
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench: control bus and both RAM ports
`include "dpr_defs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [35:0] INIT_A = 36'h976543210; // Arbitrary init value
   logic        clk_i, reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic        a_clk_i, a_en_i, a_we_i, a_sync_output_init_i;
   logic        b_clk_i, b_en_i, b_we_i, b_sync_output_init_i;
   logic [3:0]  wb_adr_i, wb_sel_i, a_wpar_i, a_rpar_o, p;
   logic [31:0] wb_dat_i, wb_dat_o, a_wdata_i, a_rdata_o, q;
   logic [8:0]  a_addr_i;
   logic [10:0] b_addr_i;
   logic [7:0]  b_wdata_i, b_rdata_o, bq;
   logic [0:0]  b_wpar_i, b_rpar_o, bp;
   int          fails, samples_checked, cycles;

   dpr_dual_port_ram #(.W_B(9), .SRVAL_A(INIT_A)) i_dpr_dual_port_ram (
      .clk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .a_clk_i, .a_en_i, .a_we_i, .a_sync_output_init_i, .a_addr_i, .a_wdata_i, .a_wpar_i, .a_rdata_o, .a_rpar_o,
      .b_clk_i, .b_en_i, .b_we_i, .b_sync_output_init_i, .b_addr_i, .b_wdata_i, .b_wpar_i, .b_rdata_o, .b_rpar_o);

   dpr_user_logic i_dpr_user_logic (.clk_i, .a_clk_o(a_clk_i), .a_en_o(a_en_i), .a_we_o(a_we_i),
      .a_init_o(a_sync_output_init_i), .a_addr_o(a_addr_i), .a_wdata_o(a_wdata_i), .a_wpar_o(a_wpar_i),
      .a_rdata_i(a_rdata_o), .a_rpar_i(a_rpar_o), .b_clk_o(b_clk_i), .b_en_o(b_en_i), .b_we_o(b_we_i),
      .b_init_o(b_sync_output_init_i), .b_addr_o(b_addr_i), .b_wdata_o(b_wdata_i), .b_wpar_o(b_wpar_i),
      .b_rdata_i(b_rdata_o), .b_rpar_i(b_rpar_o));

   // 50 MHz system clock
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Cycle limit cuts a hang short
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         complete_run();
      end
   end

   task automatic chk(input string nm, input logic [35:0] e, g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Classic single bus cycle; waits for ack, then one idle cycle
   task automatic wb(input logic we, input logic [3:0] ad, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, ad, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) fails++;
      r = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge clk_i);
   endtask

   // Reset, then bus and port sequences
   initial begin
      {reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
      wb_sel_i = 4'hf;
      repeat (12) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      wb(1'b0, `DPR_CTRL_OFF, 32'h0, q);
      chk("ctrl", `DPR_CTRL_RST, q);
      wb(1'b0, `DPR_STAT_OFF, 32'h0, q);
      chk("status", 36'h0, q);
      wb(1'b1, 4'h8, 32'hffffffff, q);
      wb(1'b0, 4'h8, 32'h0, q);
      chk("unmapped", 36'h0, q);
      // Wide write and read back, then the same word through the byte port
      i_dpr_user_logic.a_op(1, 1, 0, 9'h005, 32'h44332311, q, p);
      i_dpr_user_logic.a_op(1, 0, 0, 9'h005, 32'h0, q, p);
      chk("a_data", 36'h44332311, q);
      chk("a_par", 36'h2, p);
      i_dpr_user_logic.b_op(1, 0, 0, 11'h015, 8'h0, bq, bp);
      chk("b_data", 36'h23, bq);
      chk("b_par", 36'h1, bp);
      // Top word from A, top byte lane from B
      i_dpr_user_logic.a_op(1, 1, 0, 9'h1ff, 32'h80000000, q, p);
      i_dpr_user_logic.b_op(1, 0, 0, 11'h7ff, 8'h0, bq, bp);
      chk("b_top", 36'h80, bq);
      // B writes lane 3; A write shows the old word
      i_dpr_user_logic.b_op(1, 1, 0, 11'h017, 8'ha5, bq, bp);
      i_dpr_user_logic.a_op(1, 1, 0, 9'h005, 32'h01020304, q, p);
      chk("a_old", 36'ha5332311, q);
      // Disabled by pin, then by control bit: nothing changes
      i_dpr_user_logic.a_op(0, 1, 0, 9'h005, 32'hdeadbeef, q, p);
      chk("a_hold", 36'ha5332311, q);
      wb(1'b1, `DPR_CTRL_OFF, 32'h2, q);
      i_dpr_user_logic.a_op(1, 1, 0, 9'h005, 32'h0badf00d, q, p);
      chk("a_off", 36'ha5332311, q);
      wb(1'b1, `DPR_CTRL_OFF, 32'h3, q);
      i_dpr_user_logic.a_op(1, 0, 0, 9'h005, 32'h0, q, p);
      chk("a_new", 36'h01020304, q);
      // Synchronous output init
      i_dpr_user_logic.a_op(1, 0, 1, 9'h005, 32'h0, q, p);
      chk("a_init", {4'h0, INIT_A[31:0]}, q);
      chk("a_init_par", {32'h0, INIT_A[35:32]}, p);
      // Both ports write one word together: B's byte wins, A's other bytes stay
      fork
         i_dpr_user_logic.a_op(1, 1, 0, 9'h006, 32'h11111111, q, p);
         i_dpr_user_logic.b_op(1, 1, 0, 11'h01a, 8'hcc, bq, bp);
      join
      wb(1'b0, `DPR_STAT_OFF, 32'h0, q);
      chk("coll_set", 36'h1, q);
      wb(1'b1, `DPR_STAT_OFF, 32'h1, q);
      wb(1'b0, `DPR_STAT_OFF, 32'h0, q);
      chk("coll_clr", 36'h0, q);
      i_dpr_user_logic.a_op(1, 0, 0, 9'h006, 32'h0, q, p);
      chk("a_merge", 36'h11cc1111, q);
      // Write with byte lane 0 deselected leaves control alone
      wb_sel_i <= 4'he;
      wb(1'b1, `DPR_CTRL_OFF, 32'h0, q);
      wb_sel_i <= 4'hf;
      wb(1'b0, `DPR_CTRL_OFF, 32'h0, q);
      chk("ctrl_sel", 36'h3, q);
      complete_run();
   end
endmodule
